// file: core/sjt_cfg.svh
// Constants of the boundary-scan test access port
`ifndef SJT_CFG_SVH
`define SJT_CFG_SVH

`define SJT_IR_LEN 3
`define SJT_ID_LEN 32
`define SJT_BSR_LEN 107
// Order 48 counts from one at the TDO end, so it is index 47
`define SJT_BSR_INT_IDX 47

`define SJT_IR_EXTEST 3'h0
`define SJT_IR_IDCODE 3'h1
`define SJT_IR_SAMPLEZ 3'h2
`define SJT_IR_SAMPLE 3'h4
`define SJT_IR_BYPASS 3'h7
`define SJT_IR_CAPT 3'h1

`define SJT_ID_REV_MSB 31
`define SJT_ID_REV_LSB 29
`define SJT_ID_CFG_MSB 28
`define SJT_ID_CFG_LSB 12
`define SJT_ID_MFR_MSB 11
`define SJT_ID_MFR_LSB 1
`define SJT_ID_START 1'h1

`define SJT_SYNC_STAGES 2

`endif

// file: core/sjt_pkg.sv
// Types of the boundary-scan test access port
package sjt_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } sjt_state_t;

  typedef enum logic [1:0] {
    SEL_BYP, SEL_ID, SEL_BSR
  } sjt_dsel_t;

endpackage

// file: core/sjt_sync.sv
// Two-stage synchroniser for signals entering the system clock domain
`timescale 1ns/1ps
module sjt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic [W-1:0] d_i, // Asynchronous input
  output logic [W-1:0] q_o // Synchronised output
);
  if (W < 1) begin : g_chk
    $error("sjt_sync: width must be at least one");
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

// file: core/sjt_tap.sv
// Boundary-scan test access port of the memory device
`timescale 1ns/1ps
`include "sjt_cfg.svh"
module sjt_tap #(
  parameter int BSR_LEN = `SJT_BSR_LEN,
  parameter int BSR_INT_IDX = `SJT_BSR_INT_IDX,
  parameter logic [BSR_LEN-1:0] NC_MASK = '0,
  parameter logic [2:0] ID_REV = 3'h0,
  parameter logic [2:0] ID_DENS = 3'h1,
  parameter logic [1:0] ID_WIDTH = 2'h3,
  parameter logic ID_DLL = 1'h1,
  parameter logic ID_QUAD = 1'h0,
  parameter logic ID_BURST4 = 1'h0,
  parameter logic ID_SEPIO = 1'h0,
  // Arbitrary neutral maker code
  parameter logic [10:0] ID_MFR = 11'h2A5
) (
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic tck_i, // Test clock pin
  input wire logic tms_i, // Test mode select pin, pulled high at the pad
  input wire logic tdi_i, // Test data in pin, pulled high at the pad
  input wire logic [BSR_LEN-1:0] pad_i, // Levels seen at the pads
  output logic tdo_o, // Test data out
  output logic tdo_oe_o, // Test data out enable, high while driven
  output logic [BSR_LEN-1:0] bsr_upd_o, // Boundary update latch values
  output logic extest_o, // Pads take boundary update values
  output logic dq_hiz_o // Data pin drivers forced off
);
  localparam int IRL = `SJT_IR_LEN;
  localparam int IDL = `SJT_ID_LEN;

  if (BSR_INT_IDX >= BSR_LEN || BSR_LEN < 2) begin : g_chk
    $error("sjt_tap: boundary chain length does not fit the internal cell");
  end

  // ************************************************************
  // Input sampling
  // ************************************************************
  logic [2:0] pin_s;
  logic [BSR_LEN-1:0] pad_s;

  // Reset TMS and TDI stages to one so an idle pin reads as logic one, TCK stage to zero
  sjt_sync #(.W(3), .RST(3'h6)) u_pin_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({tms_i, tdi_i, tck_i}),
    .q_o(pin_s)
  );

  sjt_sync #(.W(BSR_LEN), .RST('0)) u_pad_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(pad_i),
    .q_o(pad_s)
  );

  logic tms_s;
  logic tdi_s;
  logic tck_s;
  logic tck_prev_q;
  logic tck_prev_d;
  logic tck_rise;
  logic tck_fall;

  always_comb begin
    tms_s = pin_s[2];
    tdi_s = pin_s[1];
    tck_s = pin_s[0];
    tck_prev_d = tck_s;
    tck_rise = tck_s & ~tck_prev_q;
    tck_fall = ~tck_s & tck_prev_q;
  end

  // ************************************************************
  // Controller and instruction register
  // ************************************************************
  sjt_pkg::sjt_state_t st_q;
  sjt_pkg::sjt_state_t st_d;
  logic [IRL-1:0] ir_sh_q;
  logic [IRL-1:0] ir_sh_d;
  logic [IRL-1:0] ir_q;
  logic [IRL-1:0] ir_d;

  always_comb begin
    st_d = st_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    if (tck_rise) begin
      case (st_q)
        sjt_pkg::TLR: st_d = tms_s ? sjt_pkg::TLR : sjt_pkg::RTI;
        sjt_pkg::RTI: st_d = tms_s ? sjt_pkg::SEL_DR : sjt_pkg::RTI;
        sjt_pkg::SEL_DR: st_d = tms_s ? sjt_pkg::SEL_IR : sjt_pkg::CAP_DR;
        sjt_pkg::CAP_DR: st_d = tms_s ? sjt_pkg::EX1_DR : sjt_pkg::SH_DR;
        sjt_pkg::SH_DR: st_d = tms_s ? sjt_pkg::EX1_DR : sjt_pkg::SH_DR;
        sjt_pkg::EX1_DR: st_d = tms_s ? sjt_pkg::UPD_DR : sjt_pkg::PAU_DR;
        sjt_pkg::PAU_DR: st_d = tms_s ? sjt_pkg::EX2_DR : sjt_pkg::PAU_DR;
        sjt_pkg::EX2_DR: st_d = tms_s ? sjt_pkg::UPD_DR : sjt_pkg::SH_DR;
        sjt_pkg::UPD_DR: st_d = tms_s ? sjt_pkg::SEL_DR : sjt_pkg::RTI;
        sjt_pkg::SEL_IR: st_d = tms_s ? sjt_pkg::TLR : sjt_pkg::CAP_IR;
        sjt_pkg::CAP_IR: st_d = tms_s ? sjt_pkg::EX1_IR : sjt_pkg::SH_IR;
        sjt_pkg::SH_IR: st_d = tms_s ? sjt_pkg::EX1_IR : sjt_pkg::SH_IR;
        sjt_pkg::EX1_IR: st_d = tms_s ? sjt_pkg::UPD_IR : sjt_pkg::PAU_IR;
        sjt_pkg::PAU_IR: st_d = tms_s ? sjt_pkg::EX2_IR : sjt_pkg::PAU_IR;
        sjt_pkg::EX2_IR: st_d = tms_s ? sjt_pkg::UPD_IR : sjt_pkg::SH_IR;
        sjt_pkg::UPD_IR: st_d = tms_s ? sjt_pkg::SEL_DR : sjt_pkg::RTI;
        default: st_d = sjt_pkg::TLR;
      endcase
      case (st_q)
        sjt_pkg::TLR: ir_d = `SJT_IR_IDCODE;
        sjt_pkg::CAP_IR: ir_sh_d = `SJT_IR_CAPT;
        sjt_pkg::SH_IR: ir_sh_d = {tdi_s, ir_sh_q[IRL-1:1]};
        sjt_pkg::UPD_IR: ir_d = ir_sh_q;
        default: ir_sh_d = ir_sh_q;
      endcase
      // Entering reset restores the identification instruction at once
      if (st_d == sjt_pkg::TLR) begin
        ir_d = `SJT_IR_IDCODE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= sjt_pkg::TLR;
      ir_sh_q <= `SJT_IR_CAPT;
      ir_q <= `SJT_IR_IDCODE;
      tck_prev_q <= 1'h0;
    end else begin
      st_q <= st_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      tck_prev_q <= tck_prev_d;
    end
  end

  // ************************************************************
  // Instruction decode
  // ************************************************************
  sjt_pkg::sjt_dsel_t dsel;
  logic is_ext;
  logic is_hiz;

  // Reserved codes fall back to bypass as a safe path
  always_comb begin
    is_ext = (ir_q == `SJT_IR_EXTEST);
    is_hiz = is_ext || (ir_q == `SJT_IR_SAMPLEZ);
    case (ir_q)
      `SJT_IR_EXTEST: dsel = sjt_pkg::SEL_BSR;
      `SJT_IR_SAMPLEZ: dsel = sjt_pkg::SEL_BSR;
      `SJT_IR_SAMPLE: dsel = sjt_pkg::SEL_BSR;
      `SJT_IR_IDCODE: dsel = sjt_pkg::SEL_ID;
      default: dsel = sjt_pkg::SEL_BYP;
    endcase
  end

  // ************************************************************
  // Data registers and outputs
  // ************************************************************
  logic [IDL-1:0] id_word;
  logic [BSR_LEN-1:0] cap_val;

  always_comb begin
    id_word = '0;
    id_word[`SJT_ID_REV_MSB:`SJT_ID_REV_LSB] = ID_REV;
    id_word[`SJT_ID_CFG_MSB:`SJT_ID_CFG_LSB] = {2'h0, ID_DENS, 1'h0, ID_WIDTH,
      1'h0, ID_DLL, 1'h0, ID_QUAD, 1'h0, ID_BURST4, 1'h0, ID_SEPIO, 1'h0};
    id_word[`SJT_ID_MFR_MSB:`SJT_ID_MFR_LSB] = ID_MFR;
    id_word[0] = `SJT_ID_START;
    // Internal and unconnected cells capture zero as their don't-care value
    cap_val = pad_s & ~NC_MASK;
    cap_val[BSR_INT_IDX] = 1'h0;
  end

  logic byp_q;
  logic byp_d;
  logic [IDL-1:0] id_q;
  logic [IDL-1:0] id_d;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_d;
  logic [BSR_LEN-1:0] upd_q;
  logic [BSR_LEN-1:0] upd_d;
  logic tdo_q;
  logic tdo_d;
  logic oe_q;
  logic oe_d;
  logic ext_q;
  logic ext_d;
  logic hiz_q;
  logic hiz_d;
  logic dr_lsb;

  always_comb begin
    byp_d = byp_q;
    id_d = id_q;
    bsr_d = bsr_q;
    upd_d = upd_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    ext_d = is_ext;
    hiz_d = is_hiz;
    case (dsel)
      sjt_pkg::SEL_ID: dr_lsb = id_q[0];
      sjt_pkg::SEL_BSR: dr_lsb = bsr_q[0];
      default: dr_lsb = byp_q;
    endcase
    if (tck_rise) begin
      if (st_q == sjt_pkg::UPD_IR && ir_sh_q == `SJT_IR_BYPASS) begin
        byp_d = 1'h0;
      end
      case (st_q)
        sjt_pkg::CAP_DR: begin
          case (dsel)
            sjt_pkg::SEL_ID: id_d = id_word;
            sjt_pkg::SEL_BSR: bsr_d = cap_val;
            default: byp_d = 1'h0;
          endcase
        end
        sjt_pkg::SH_DR: begin
          case (dsel)
            sjt_pkg::SEL_ID: id_d = {tdi_s, id_q[IDL-1:1]};
            sjt_pkg::SEL_BSR: bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
            default: byp_d = tdi_s;
          endcase
        end
        sjt_pkg::UPD_DR: begin
          if (dsel == sjt_pkg::SEL_BSR) begin
            upd_d = bsr_q;
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      if (st_q == sjt_pkg::SH_IR) begin
        tdo_d = ir_sh_q[0];
        oe_d = 1'h1;
      end else if (st_q == sjt_pkg::SH_DR) begin
        tdo_d = dr_lsb;
        oe_d = 1'h1;
      end else begin
        oe_d = 1'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      byp_q <= 1'h0;
      id_q <= '0;
      bsr_q <= '0;
      upd_q <= '0;
      tdo_q <= 1'h0;
      oe_q <= 1'h0;
      ext_q <= 1'h0;
      hiz_q <= 1'h0;
    end else begin
      byp_q <= byp_d;
      id_q <= id_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      ext_q <= ext_d;
      hiz_q <= hiz_d;
    end
  end

  // Pads see only the update latch, never stored memory data
  assign tdo_o = tdo_q;
  assign tdo_oe_o = oe_q;
  assign bsr_upd_o = upd_q;
  assign extest_o = ext_q;
  assign dq_hiz_o = hiz_q;
endmodule

// file: testbench/sjt_tap_assertions.sv
// Port checks of the boundary-scan test access port
`timescale 1ns/1ps
module sjt_tap_assertions #(
  parameter int BSR_LEN = 107
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire logic tck_i, // Test clock pin
  input wire logic tdo_o, // Test data out
  input wire logic tdo_oe_o, // Test data out enable
  input wire logic [BSR_LEN-1:0] bsr_upd_o, // Boundary update latch
  input wire logic extest_o, // Pads from boundary latch
  input wire logic dq_hiz_o // Data drivers off
);
  // ****************
  // Link timing
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_tdo_fall: assert property (
    $changed(tdo_o) |-> !$past(tck_i, 1) && !$past(tck_i, 3))
    else $error("tdo moved away from a clock fall");
  a_tdo_stand: assert property (
    $changed(tdo_o) |=> $stable(tdo_o) [*6])
    else $error("tdo did not stand");
  a_oe_fall: assert property (
    $changed(tdo_oe_o) |-> !$past(tck_i, 1) && !$past(tck_i, 3))
    else $error("tdo enable moved away from a clock fall");
  a_oe_stand: assert property (
    $changed(tdo_oe_o) |=> $stable(tdo_oe_o) [*6])
    else $error("tdo enable did not stand");
  a_mode_rise: assert property (
    $changed(extest_o) || $changed(dq_hiz_o) |-> $past(tck_i, 2))
    else $error("pad mode moved away from a clock rise");
  a_extest_hiz: assert property (
    extest_o |-> dq_hiz_o)
    else $error("extest with data drivers on");
  a_upd_rise: assert property (
    $changed(bsr_upd_o) |-> $past(tck_i, 2))
    else $error("update latch moved away from a clock rise");
  a_upd_stand: assert property (
    $changed(bsr_upd_o) |=> $stable(bsr_upd_o) [*6])
    else $error("update latch did not stand");
  c_shift: cover property ($rose(tdo_oe_o));
  c_extest: cover property ($rose(extest_o));
  c_samplez: cover property ($rose(dq_hiz_o) && !extest_o);
  c_update: cover property ($changed(bsr_upd_o));
endmodule
bind sjt_tap sjt_tap_assertions #(.BSR_LEN(BSR_LEN)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .bsr_upd_o(bsr_upd_o),
  .extest_o(extest_o), .dq_hiz_o(dq_hiz_o));

// file: testbench/sjt_jtag_ctl.sv
// Behavioural external test controller driving the scan link
`timescale 1ns/1ps
module sjt_jtag_ctl (
  input wire logic clk_i, // Bench clock
  input wire logic tdo_i, // Resolved test data out wire
  output logic tck_o, // Test clock, still between frames
  output logic tms_o, // Mode select
  output logic tdi_o // Data in
);
  // ****************
  // Link driver
  // ****************
  initial begin
    tck_o <= 1'h0;
    tms_o <= 1'h1;
    tdi_o <= 1'h1;
  end
  // Mode and data move at the fall, four cycles clear of the rise either side
  task automatic step(input logic m, input logic d, output logic o);
    tck_o <= 1'h0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'h1;
    #1 o = tdo_i;
    repeat (4) @(posedge clk_i);
  endtask
  // Only defined codes are ever loaded here
  task automatic scan(input logic ir, input int n, input logic [106:0] din,
                      output logic [106:0] dout);
    logic o;
    dout = '0;
    step(1'h0, 1'h1, o);
    step(1'h1, 1'h1, o);
    if (ir) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    tck_o <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// file: testbench/sjt_tap_tb.sv
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/1ps
module sjt_tap_tb;
  // Arbitrary maker code for the bench
  localparam logic [10:0] MFR = 11'h3C6;
  localparam logic [31:0] ID = {3'h0, 17'h01680, MFR, 1'h1};
  localparam logic [106:0] PADS = 107'({27{4'hA}});
  logic clk, nrst, tck, tms, tdi, tdo, tdo_oe, extest, dq_hiz, tdo_w;
  logic [106:0] pad, upd, dout;
  int fails = 0;
  int compares = 0;
  // A released wire shows the inverse of its last level
  assign tdo_w = tdo ^ ~tdo_oe;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  sjt_tap #(.ID_MFR(MFR)) dut_u (.clk_i(clk), .nrst_i(nrst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pad_i(pad), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .bsr_upd_o(upd),
    .extest_o(extest), .dq_hiz_o(dq_hiz));
  sjt_jtag_ctl ctl_u (.clk_i(clk), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  // ****************
  // Checks and tests
  // ****************
  task automatic check(input string what, input logic [106:0] exp, input logic [106:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_id();
    logic [106:0] din;
    din = 107'(64'h0123456789ABCDEF);
    check("reset pads", 107'h0, 107'({extest, dq_hiz}));
    ctl_u.scan(1'h0, 64, din, dout);
    check("id word", 107'(ID), 107'(dout[31:0]));
    check("id through", 107'(din[31:0]), 107'(dout[63:32]));
    check("tdo enable", 107'h0, 107'(tdo_oe));
    $display("id test done");
  endtask
  task automatic t_bypass();
    ctl_u.scan(1'h1, 3, 107'(3'h7), dout);
    check("ir capture", 107'(3'h1), 107'(dout[2:0]));
    ctl_u.scan(1'h0, 9, 107'(8'hA5), dout);
    check("bypass", 107'({8'hA5, 1'h0}), 107'(dout[8:0]));
    $display("bypass test done");
  endtask
  task automatic t_boundary();
    logic [2:0] code;
    logic [106:0] din, exp;
    exp = PADS;
    exp[47] = 1'h0;
    pad <= PADS;
    for (int k = 0; k < 3; k++) begin
      code = 3'(4 - 2 * k);
      din = ~PADS ^ 107'(k);
      ctl_u.scan(1'h1, 3, 107'(code), dout);
      check("data hiz", 107'(code != 3'h4), 107'(dq_hiz));
      check("extest", 107'(code == 3'h0), 107'(extest));
      ctl_u.scan(1'h0, 107, din, dout);
      check("capture", exp, dout);
      check("update", din, upd);
    end
    $display("boundary test done");
  endtask
  task automatic t_tlr();
    logic o;
    for (int i = 0; i < 5; i++) ctl_u.step(1'h1, 1'h1, o);
    repeat (2) @(posedge clk);
    check("tlr pads", 107'h0, 107'({extest, dq_hiz}));
    ctl_u.scan(1'h0, 32, 107'h0, dout);
    check("tlr id", 107'(ID), 107'(dout[31:0]));
    $display("reset state test done");
  endtask
  initial begin
    nrst <= 1'h0;
    pad <= '0;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    t_id();
    t_bypass();
    t_boundary();
    t_tlr();
    end_of_test();
  end
  // The tests need some 4100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule
